// ---- dv/dtx_checker.sv ----
// Line overhead, AIS, payload and interrupt checks for the unit top
`timescale 1ns/1ps
module dtx_checker #(parameter int ADDR_W = 8) (
  // Clock, reset, write bus
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  // Stream and interrupt
  input wire logic payload_bit,
  input wire logic payload_slot,
  input wire logic line_data,
  input wire logic frame_start,
  input wire logic irq_out_n
);
  localparam logic [8:0] FAW = 9'h1d0;
  logic [7:0] s_r;
  logic [2:0] q_r;
  logic seen_r;
  logic wr;
  logic m0;
  logic g;
  int pc_r;
  int ix;
  int b;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Shadow only works while AW and W are offered together
  assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  always_comb begin
    ix = frame_start ? 0 : pc_r;
    b = ix % 294 / 49;
    m0 = !s_r[7] && seen_r && !s_r[3] && ix % 49 == 0;
    g = s_r[7] && seen_r && !s_r[3];
  end
  always_ff @(posedge aclk) begin
    pc_r <= ix + 1;
    if (!aresetn || wr) begin
      q_r <= 3'h0;
      seen_r <= 1'b0;
    end else begin
      q_r <= q_r + 3'(q_r != 3'h7);
      seen_r <= seen_r || (frame_start && q_r > 3'h4);
    end
    if (!aresetn)
      s_r <= 8'h00;
    else if (wr && s_axi_awaddr == 0 && s_axi_wstrb[0])
      s_r <= s_axi_wdata[7:0];
  end
  property p_len;
    frame_start && seen_r |-> pc_r == (s_r[7] ? 840 : 1176);
  endproperty
  a_len: assert property (p_len)
    else $error("bad frame length");
  property p_m;
    m0 && b == 0 |-> line_data == (s_r[5] ^ (ix >= 882 ? !s_r[2] : ix >= 294));
  endproperty
  a_m: assert property (p_m)
    else $error("bad M or X bit");
  property p_f;
    m0 && (b == 2 || b == 5) |-> line_data == ((b == 5) ^ s_r[4]);
  endproperty
  a_f: assert property (p_f)
    else $error("bad F bit");
  property p_faw;
    g && ix < 9 |-> (line_data ^ s_r[4]) == FAW[8 - ix];
  endproperty
  a_faw: assert property (p_faw)
    else $error("bad alignment word");
  property p_rai;
    g && ix == 9 |-> line_data == s_r[2];
  endproperty
  a_rai: assert property (p_rai)
    else $error("bad alarm bit");
  property p_ais;
    s_r[3] && q_r == 3'h7 |-> line_data;
  endproperty
  a_ais: assert property (p_ais)
    else $error("AIS not all ones");
  property p_pay;
    payload_slot && !s_r[3] && q_r == 3'h7 |=> line_data == $past(payload_bit);
  endproperty
  a_pay: assert property (p_pay)
    else $error("payload altered");
  property p_irq;
    !s_r[0] && q_r == 3'h7 |-> irq_out_n;
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq while disabled");
endmodule

bind dtx_top dtx_checker #(.ADDR_W(ADDR_W)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .payload_bit(payload_bit), .payload_slot(payload_slot),
  .line_data(line_data), .frame_start(frame_start), .irq_out_n(irq_out_n));

// ---- dv/dtx_rx_model.sv ----
// Remote terminal: length and ones count of each received frame
`timescale 1ns/1ps
module dtx_rx_model (
  // Line in
  input wire logic aclk,
  input wire logic line_data,
  input wire logic frame_start,
  // Last frame
  output int flen,
  output int ones
);
  int c;
  int o;
  always @(posedge aclk) begin
    if (frame_start) begin
      flen <= c;
      ones <= o;
      c <= 1;
      o <= int'(line_data);
    end else begin
      c <= c + 1;
      o <= o + int'(line_data);
    end
  end
endmodule

// ---- dv/tb.sv ----
// Self-checking bench for the transmit overhead controller
`timescale 1ns/1ps
`include "dtx_params.svh"
module tb;
  localparam logic [1:0] OK = `DTX_RESP_OKAY;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awv = 0, wv = 0, brd = 0, arv = 0, rrd = 0, pb = 0;
  logic [3:0] strb = 4'hf, lr = 4'h0;
  logic [31:0] wd = 0, rdat;
  logic awr, wrdy, bv, arr, rv, slot, ld, fs, irq_n;
  logic [1:0] br, rr;
  logic chk_on = 0, ais = 0, pend = 0, pexp = 0;
  int n_errors = 0, n_tests = 0, flen, ones, cyc = 0;
  logic [7:0] cf [13] = '{8'h00, 8'h20, 8'h10, 8'h04, 8'h24, 8'h34,
    8'h80, 8'h90, 8'h84, 8'ha6, 8'hc4, 8'h08, 8'h88};
  dtx_top #(.ADDR_W(8)) DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(strb),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rrd), .payload_bit(pb), .payload_slot(slot),
    .loop_request_in(lr), .line_data(ld), .frame_start(fs),
    .irq_out_n(irq_n));
  dtx_rx_model u_rx (.aclk(aclk), .line_data(ld), .frame_start(fs),
    .flen(flen), .ones(ones));
  initial forever #25 aclk = ~aclk;
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t value %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_bit(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t bit %b exp %b", $time, g, e);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    // Wait until bvalid is seen; only the bench timeout ends a wait that never sees it
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bv);
    cmp(32'(br), 32'(r));
    brd <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    cmp(rdat, e);
    cmp(32'(rr), 32'(r));
    rrd <= 1'b0;
  endtask
  task automatic frm();
    for (int k = 0; k < 1300; k++) begin
      @(posedge aclk);
      if (fs) break;
    end
    @(posedge aclk);
  endtask
  task automatic wirq(input logic e);
    for (int k = 0; k < 12 && irq_n !== e; k++)
      @(posedge aclk);
    cmp_bit(irq_n, e);
  endtask
  task final_report();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Payload pass-through model; AIS expects ones on every bit
  always @(posedge aclk) begin
    if (pend && chk_on)
      cmp_bit(ld, pexp);
    pend <= slot || ais;
    pexp <= ais | pb;
    pb <= 1'($urandom);
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    logic [31:0] v;
    void'($urandom(32'h645f));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++)
      axr(8'(i * 4), i == 4 ? 32'hf : 32'h0, OK);
    axr(8'h14, 32'h0, `DTX_RESP_SLVERR);
    axw(8'h14, 32'h1, `DTX_RESP_SLVERR);
    axw(`DTX_OFF_STS, 32'hf, OK);
    axr(`DTX_OFF_STS, 32'h0, OK);
    v = $urandom;
    axw(`DTX_OFF_LBC, v, OK);
    strb <= 4'he;
    axw(`DTX_OFF_LBC, ~v, OK);
    strb <= 4'hf;
    axr(`DTX_OFF_LBC, v & 32'h3, OK);
    v = $urandom;
    axw(`DTX_OFF_EN, v, OK);
    axr(`DTX_OFF_EN, v & 32'hf, OK);
    axw(`DTX_OFF_EN, 32'hf, OK);
    axw(`DTX_OFF_CFG, 32'h1, OK);
    lr <= 4'h4;
    wirq(1'b0);
    axr(`DTX_OFF_STS, 32'h4, OK);
    axw(`DTX_OFF_CLR, 32'h4, OK);
    wirq(1'b1);
    axw(`DTX_OFF_EN, 32'hb, OK);
    lr <= 4'h0;
    repeat (4) @(posedge aclk);
    lr <= 4'h4;
    repeat (8) @(posedge aclk);
    cmp_bit(irq_n, 1'b1);
    axw(`DTX_OFF_EN, 32'hf, OK);
    wirq(1'b0);
    axw(`DTX_OFF_CFG, 32'h0, OK);
    wirq(1'b1);
    axw(`DTX_OFF_CLR, 32'hf, OK);
    axr(`DTX_OFF_STS, 32'h0, OK);
    for (int i = 0; i < 13; i++) begin
      chk_on <= 1'b0;
      ais <= cf[i][3];
      axw(`DTX_OFF_CFG, 32'(cf[i]), OK);
      axr(`DTX_OFF_CFG, 32'(cf[i]), OK);
      frm();
      chk_on <= 1'b1;
      frm();
      frm();
      cmp(flen, cf[i][7] ? 840 : 1176);
      if (cf[i][3]) cmp(ones, flen);
    end
    final_report();
  end
endmodule

// ---- hw/dtx_params.svh ----
// Register map, field positions, reset values and frame geometry
`ifndef DTX_PARAMS_SVH
`define DTX_PARAMS_SVH

// Byte offsets of the registers
`define DTX_OFF_CFG 8'h00
`define DTX_OFF_LBC 8'h04
`define DTX_OFF_STS 8'h08
`define DTX_OFF_CLR 8'h0c
`define DTX_OFF_EN 8'h10

// unit_tx_configuration field positions
`define DTX_CFG_ITU 7
`define DTX_CFG_M_INVERT 5
`define DTX_CFG_F_INVERT 4
`define DTX_CFG_AIS 3
`define DTX_CFG_FERF 2
`define DTX_CFG_RES 1
`define DTX_CFG_IRQ_EN 0

// Reset values
`define DTX_RST_CFG 8'h00
`define DTX_RST_LBC 2'h0
`define DTX_RST_EN 4'hf

// AXI responses
`define DTX_RESP_OKAY 2'h0
`define DTX_RESP_SLVERR 2'h2

// DS2 frame: 4 subframes of 6 blocks of 49 bits
`define DTX_DS2_BLK_BITS 6'h31
`define DTX_DS2_BLKS 3'h6
`define DTX_DS2_SUBS 3'h4
`define DTX_DS2_F1_BLK 3'h5
`define DTX_DS2_F0_BLK 3'h2

// G.747 frame: 840 bits in four sets of 210
`define DTX_ITU_BITS 10'h348
`define DTX_ITU_SET_BITS 10'h0d2
`define DTX_ITU_FAW 9'h1d0
`define DTX_ITU_FAW_LEN 10'h009
`define DTX_ITU_RAI_POS 10'h009
`define DTX_ITU_RES_POS 10'h00a
`define DTX_ITU_JC_LEN 8'h03

`endif

// ---- hw/dtx_pkg.sv ----
// Types shared by the transmit overhead controller
package dtx_pkg;

  typedef enum logic [2:0] {
    DTX_K_PAY = 3'h0,
    DTX_K_M = 3'h1,
    DTX_K_C = 3'h2,
    DTX_K_F = 3'h3,
    DTX_K_FAW = 3'h4,
    DTX_K_RAI = 3'h5,
    DTX_K_RES = 3'h6,
    DTX_K_JC = 3'h7
  } dtx_kind_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_got;
    logic aw_bad;
    logic [7:0] awaddr;
    logic w_got;
    logic w_lane0;
    logic [7:0] wdata;
    logic [7:0] cfg;
    logic [1:0] lbc;
    logic [3:0] sts;
    logic [3:0] en;
    logic [3:0] lr_s1;
    logic [3:0] lr_s2;
    logic [3:0] lr_prev;
    logic fmt;
    logic [5:0] pos;
    logic [2:0] blk;
    logic [1:0] sub;
    logic [9:0] gcnt;
    logic line_data;
    logic frame_start;
    logic payload_slot;
    logic irq_n;
  } dtx_state_t;

endpackage

// ---- hw/dtx_top.sv ----
// Transmit overhead and diagnostic control of one second-order mux unit
//
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`include "dtx_params.svh"

module dtx_top
  import dtx_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Tributary payload, same clock
  input wire logic payload_bit,
  output logic payload_slot,
  // Loop request pins from the receive side
  input wire logic [3:0] loop_request_in,
  // Line side
  output logic line_data,
  output logic frame_start,
  output logic irq_out_n
);

  // Set boundaries inside the 840-bit frame
  localparam logic [9:0] SET1_START = `DTX_ITU_SET_BITS;
  localparam logic [9:0] SET2_START = SET1_START + `DTX_ITU_SET_BITS;
  localparam logic [9:0] SET3_START = SET2_START + `DTX_ITU_SET_BITS;
  localparam logic [9:0] JC_LEN = {2'h0, `DTX_ITU_JC_LEN};
  localparam logic [8:0] FAW_WORD = `DTX_ITU_FAW;

  // Refuse widths and frame figures the logic cannot serve
  if (ADDR_W < 8) begin : g_bad_addr_w
    $error("dtx_top: ADDR_W must be at least 8");
  end
  // Four equal sets must fill the frame exactly
  if (SET3_START + `DTX_ITU_SET_BITS != `DTX_ITU_BITS) begin : g_bad_sets
    $error("dtx_top: sets do not fill the frame");
  end
  // Alignment word bits are picked by the low counter bits
  if (`DTX_ITU_FAW_LEN != 10'h009) begin : g_bad_faw
    $error("dtx_top: alignment word must be nine bits");
  end
  if (`DTX_ITU_RAI_POS < `DTX_ITU_FAW_LEN) begin : g_bad_rai
    $error("dtx_top: alarm bit overlaps the alignment word");
  end
  // F blocks must exist inside each subframe
  if (`DTX_DS2_F1_BLK >= `DTX_DS2_BLKS) begin : g_bad_fblk
    $error("dtx_top: F block beyond the subframe");
  end

  dtx_state_t st;
  dtx_state_t nxt;

  // Slot type of a bit position in the current format
  function automatic dtx_kind_t slot_kind(
    input logic fmt,
    input logic [5:0] pos,
    input logic [2:0] blk,
    input logic [9:0] gcnt
  );
    dtx_kind_t k;
    logic [9:0] in_set;
    k = DTX_K_PAY;
    in_set = 10'h000;
    if (fmt) begin
      // Offset of the bit inside its 210-bit set
      if (gcnt >= SET3_START) begin
        in_set = gcnt - SET3_START;
      end else if (gcnt >= SET2_START) begin
        in_set = gcnt - SET2_START;
      end else if (gcnt >= SET1_START) begin
        in_set = gcnt - SET1_START;
      end else begin
        in_set = gcnt;
      end
      if (gcnt < SET1_START) begin
        if (gcnt < `DTX_ITU_FAW_LEN) begin
          k = DTX_K_FAW;
        end else if (gcnt == `DTX_ITU_RAI_POS) begin
          k = DTX_K_RAI;
        end else if (gcnt == `DTX_ITU_RES_POS) begin
          k = DTX_K_RES;
        end
      end else if (in_set < JC_LEN) begin
        k = DTX_K_JC;
      end
    end else if (pos == 6'h00) begin
      if (blk == 3'h0) begin
        k = DTX_K_M;
      end else if (blk == `DTX_DS2_F0_BLK || blk == `DTX_DS2_F1_BLK) begin
        k = DTX_K_F;
      end else begin
        k = DTX_K_C;
      end
    end
    return k;
  endfunction

  logic aw_take;
  logic w_take;
  logic ar_take;
  logic [7:0] ar_off;
  logic ar_bad;
  logic [3:0] lr_rise;
  logic [3:0] clr_bits;
  logic ais;
  logic ferf;
  logic x_bit;
  logic m_bit;
  logic f_bit;
  logic out_bit;
  logic restart;
  dtx_kind_t kind_now;

  // One edge detector per loop request line
  for (genvar i = 0; i < 4; i++) begin : g_lr
    assign lr_rise[i] = st.lr_s2[i] & ~st.lr_prev[i];
  end

  always_comb begin
    nxt = st;
    aw_take = s_axi_awvalid & st.awready;
    w_take = s_axi_wvalid & st.wready;
    ar_take = s_axi_arvalid & st.arready;
    ar_off = s_axi_araddr[7:0];
    ar_bad = (s_axi_araddr >> 8) != '0;
    clr_bits = 4'h0;

    // Write address and data may arrive in either order
    if (aw_take) begin
      nxt.aw_got = 1'b1;
      nxt.awaddr = s_axi_awaddr[7:0];
      nxt.aw_bad = (s_axi_awaddr >> 8) != '0;
    end
    if (w_take) begin
      nxt.w_got = 1'b1;
      nxt.wdata = s_axi_wdata[7:0];
      nxt.w_lane0 = s_axi_wstrb[0];
    end
    if (st.bvalid && s_axi_bready) begin
      nxt.bvalid = 1'b0;
    end
    if (st.aw_got && st.w_got && !st.bvalid) begin
      nxt.aw_got = 1'b0;
      nxt.w_got = 1'b0;
      nxt.bvalid = 1'b1;
      nxt.bresp = `DTX_RESP_OKAY;
      if (st.aw_bad) begin
        nxt.bresp = `DTX_RESP_SLVERR;
      end else begin
        case (st.awaddr)
          `DTX_OFF_CFG: begin
            if (st.w_lane0) begin
              nxt.cfg = st.wdata;
            end
          end
          `DTX_OFF_LBC: begin
            // One code pair for both directions
            if (st.w_lane0) begin
              nxt.lbc = st.wdata[1:0];
            end
          end
          `DTX_OFF_STS: begin
          end
          `DTX_OFF_CLR: begin
            if (st.w_lane0) begin
              clr_bits = st.wdata[3:0];
            end
          end
          `DTX_OFF_EN: begin
            if (st.w_lane0) begin
              nxt.en = st.wdata[3:0];
            end
          end
          default: begin
            nxt.bresp = `DTX_RESP_SLVERR;
          end
        endcase
      end
    end
    nxt.awready = !nxt.aw_got && !nxt.bvalid;
    nxt.wready = !nxt.w_got && !nxt.bvalid;

    // Read channel, one outstanding read
    if (st.rvalid && s_axi_rready) begin
      nxt.rvalid = 1'b0;
    end
    if (ar_take) begin
      nxt.rvalid = 1'b1;
      nxt.rresp = `DTX_RESP_OKAY;
      nxt.rdata = 32'h0000_0000;
      if (ar_bad) begin
        nxt.rresp = `DTX_RESP_SLVERR;
      end else begin
        case (ar_off)
          `DTX_OFF_CFG: nxt.rdata[7:0] = st.cfg;
          `DTX_OFF_LBC: nxt.rdata[1:0] = st.lbc;
          `DTX_OFF_STS: nxt.rdata[3:0] = st.sts;
          `DTX_OFF_CLR: nxt.rdata = 32'h0000_0000;
          `DTX_OFF_EN: nxt.rdata[3:0] = st.en;
          default: nxt.rresp = `DTX_RESP_SLVERR;
        endcase
      end
    end
    nxt.arready = !nxt.rvalid;

    // Loop request pins: two-stage sync, then rising edge
    nxt.lr_s1 = loop_request_in;
    nxt.lr_s2 = st.lr_s1;
    nxt.lr_prev = st.lr_s2;
    // A new request beats a clear in the same cycle
    nxt.sts = (st.sts & ~clr_bits) | lr_rise;
    nxt.irq_n = !(st.cfg[`DTX_CFG_IRQ_EN] && |(st.sts & st.en));

    // Frame position counters
    // Format change restarts the frame so no mixed frame goes out
    restart = st.cfg[`DTX_CFG_ITU] != st.fmt;
    nxt.fmt = st.cfg[`DTX_CFG_ITU];
    if (restart) begin
      nxt.pos = 6'h00;
      nxt.blk = 3'h0;
      nxt.sub = 2'h0;
      nxt.gcnt = 10'h000;
    end else if (st.fmt) begin
      // 840-bit G.747 frame
      if (st.gcnt == `DTX_ITU_BITS - 10'h001) begin
        nxt.gcnt = 10'h000;
      end else begin
        nxt.gcnt = st.gcnt + 10'h001;
      end
    end else begin
      if (st.pos == `DTX_DS2_BLK_BITS - 6'h01) begin
        nxt.pos = 6'h00;
        if (st.blk == `DTX_DS2_BLKS - 3'h1) begin
          nxt.blk = 3'h0;
          if (st.sub == 2'(`DTX_DS2_SUBS - 3'h1)) begin
            nxt.sub = 2'h0;
          end else begin
            nxt.sub = st.sub + 2'h1;
          end
        end else begin
          nxt.blk = st.blk + 3'h1;
        end
      end else begin
        nxt.pos = st.pos + 6'h01;
      end
    end

    // Build the current line bit
    ais = st.cfg[`DTX_CFG_AIS];
    ferf = st.cfg[`DTX_CFG_FERF];
    x_bit = !(ferf && !ais);
    case (st.sub)
      2'h0: m_bit = 1'b0;
      2'h3: m_bit = x_bit;
      default: m_bit = 1'b1;
    endcase
    m_bit = m_bit ^ st.cfg[`DTX_CFG_M_INVERT];
    f_bit = (st.blk == `DTX_DS2_F1_BLK) ^
      st.cfg[`DTX_CFG_F_INVERT];
    kind_now = slot_kind(st.fmt, st.pos, st.blk, st.gcnt);
    case (kind_now)
      DTX_K_PAY: out_bit = payload_bit;
      DTX_K_M: out_bit = m_bit;
      DTX_K_F: out_bit = f_bit;
      DTX_K_FAW: begin
        out_bit = FAW_WORD[4'h8 - st.gcnt[3:0]] ^
          st.cfg[`DTX_CFG_F_INVERT];
      end
      DTX_K_RAI: out_bit = ferf;
      DTX_K_RES: out_bit = st.cfg[`DTX_CFG_RES];
      DTX_K_C: out_bit = 1'b0;
      DTX_K_JC: out_bit = 1'b0;
      default: out_bit = 1'b0;
    endcase
    // AIS overrides every slot, payload included
    nxt.line_data = out_bit | ais;
    nxt.frame_start = st.fmt ? (st.gcnt == 10'h000) :
      (st.pos == 6'h00 && st.blk == 3'h0 && st.sub == 2'h0);
    // Announce a payload slot one cycle ahead of its edge
    nxt.payload_slot = !restart &&
      (slot_kind(nxt.fmt, nxt.pos, nxt.blk, nxt.gcnt) == DTX_K_PAY);

    if (!aresetn) begin
      nxt = '0;
      nxt.cfg = `DTX_RST_CFG;
      nxt.lbc = `DTX_RST_LBC;
      nxt.en = `DTX_RST_EN;
      nxt.irq_n = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    st <= nxt;
  end

  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bresp = st.bresp;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_arready = st.arready;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rvalid = st.rvalid;
  assign payload_slot = st.payload_slot;
  assign line_data = st.line_data;
  assign frame_start = st.frame_start;
  assign irq_out_n = st.irq_n;

endmodule
